// ---- design/rcf_pkg.sv ----
/*
 * Constants shared by the reset cause flag block: register offsets, bit
 * positions, reset values and bus widths.
 * Assumes a 32-bit APB register bus and one core clock.
 */
`default_nettype none

package rcf_pkg;

    // Bus widths
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          FLAG_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  OFF_FLAGS     = 8'h00;
    localparam logic [7:0]  OFF_EVENTS    = 8'h04;
    localparam logic [7:0]  OFF_MASK      = 8'h08;

    // Bit positions, shared by flags, event status and mask
    localparam int          BIT_STK_OVF   = 7;
    localparam int          BIT_STK_UNF   = 6;
    localparam int          BIT_UNUSED    = 5;
    localparam int          BIT_WDT       = 4;
    localparam int          BIT_MASTER_CLEAR_PIN      = 3;
    localparam int          BIT_RST_INSN  = 2;
    localparam int          BIT_POWER_ON  = 1;
    localparam int          BIT_BROWNOUT  = 0;

    // Value after power-on: active-low cause flags idle high, power and brown-out low
    localparam logic [7:0]  FLAGS_RESET   = 8'h1C;
    // Bits that firmware may write; the unused position is excluded
    localparam logic [7:0]  FLAGS_WR_MASK = 8'hDF;
    // Power-on is reported as a pending event right after reset
    localparam logic [7:0]  EVENTS_RESET  = 8'h02;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [31:0] WORD_ZERO     = 32'h00000000;
    localparam logic [23:0] UPPER_ZERO    = 24'h000000;

endpackage : rcf_pkg

`default_nettype wire

// ---- design/rcf_regif_if.sv ----
/*
 * Carrier between the APB slave and the register core.
 * Assumes both ends run on pclk; strobes are one cycle wide.
 */
`default_nettype none

interface rcf_regif_if;
    logic                        rd_req;
    logic                        wr_req;
    logic [rcf_pkg::ADDR_W-1:0]  addr;
    logic [rcf_pkg::DATA_W-1:0]  wdata;
    logic [rcf_pkg::DATA_W-1:0]  rdata;
    logic                        err;

    modport bus  (output rd_req, output wr_req, output addr, output wdata,
                  input rdata, input err);
    modport core (input rd_req, input wr_req, input addr, input wdata,
                  output rdata, output err);
endinterface : rcf_regif_if

`default_nettype wire

// ---- design/rcf_sync.sv ----
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit changes slowly compared with pclk; bits are not coherent.
 */
`default_nettype none

module rcf_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : rcf_sync

`default_nettype wire

// ---- design/rcf_apb_slave.sv ----
/*
 * APB slave front end: one wait state, then pready with registered data.
 * Assumes a compliant APB master that holds the request until pready.
 */
`default_nettype none

module rcf_apb_slave (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rcf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rcf_pkg::DATA_W-1:0] pwdata,
    output var  logic [rcf_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    rcf_regif_if.bus                        regif
);

    typedef enum logic {RCF_IDLE, RCF_RESP} rcf_state_t;

    rcf_state_t                 state;
    rcf_state_t                 next_state;
    logic [rcf_pkg::DATA_W-1:0] next_prdata;
    logic                       next_pready;
    logic                       next_pslverr;
    logic                       access;

    // First access cycle captures the answer; the second one completes
    assign access       = psel && penable && (state == RCF_IDLE);
    assign regif.addr   = paddr;
    assign regif.wdata  = pwdata;
    // Read side effects go with the capture edge so nothing read is lost
    assign regif.rd_req = access && !pwrite;
    // Writes land only on the completing edge
    assign regif.wr_req = psel && penable && pready && pwrite && !pslverr;

    // Handshake sequencing
    always_comb begin
        next_state   = state;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        case (state)
            RCF_IDLE: begin
                if (access) begin
                    next_state   = RCF_RESP;
                    next_pready  = 1'b1;
                    next_pslverr = regif.err;
                    next_prdata  = pwrite ? rcf_pkg::WORD_ZERO : regif.rdata;
                end
            end
            RCF_RESP: begin
                next_state = RCF_IDLE;
            end
            default: begin
                next_state = RCF_IDLE;
            end
        endcase
    end

    // Registered answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= RCF_IDLE;
            prdata  <= rcf_pkg::WORD_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state   <= next_state;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : rcf_apb_slave

`default_nettype wire

// ---- design/rcf_top.sv ----
/*
 * Reset cause flag register with APB access, event status and interrupt.
 * Assumes presetn is the power-on reset of the core domain; every other
 * reset source arrives as an asynchronous level from its own block.
 */
// Functional notes
// - A stack overflow sets the overflow flag, which stays 0 until one occurs or firmware clears it.
// - A stack underflow sets the underflow flag, which stays 0 until one occurs or firmware clears it.
// - Bit 5 is not implemented, always reads zero and ignores writes.
// - A watchdog timeout clears the watchdog flag, which otherwise reads 1 and firmware can re-arm.
// - A master-clear pin reset clears the master-clear flag, which firmware can set back to 1.
// - A reset instruction clears the instruction flag, which otherwise reads 1 and can be re-armed.
// - The power-on bit reads 0 after power-on and firmware writes it to 1 to detect the next.
// - The brown-out bit reads 0 after brown-out or power-on and firmware writes it back to 1.
`default_nettype none

module rcf_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rcf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rcf_pkg::DATA_W-1:0] pwdata,
    output var  logic [rcf_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       stack_overflow,
    input  wire logic                       stack_underflow,
    input  wire logic                       watchdog_timeout,
    input  wire logic                       master_clear_pin_n,
    input  wire logic                       reset_instruction,
    input  wire logic                       brownout,
    output var  logic [rcf_pkg::FLAG_W-1:0] reset_cause_flags,
    output var  logic                       irq
);

    localparam int N_SRC = 6;

    // Source index inside the synchronised vector
    localparam int SRC_OVF  = 0;
    localparam int SRC_UNF  = 1;
    localparam int SRC_WDT  = 2;
    localparam int SRC_MASTER_CLEAR_PIN = 3;
    localparam int SRC_RI   = 4;
    localparam int SRC_BOR  = 5;

    rcf_regif_if regif ();

    logic [N_SRC-1:0]           src_raw;
    logic [N_SRC-1:0]           src_sync;
    logic [N_SRC-1:0]           src_prev;
    logic [N_SRC-1:0]           next_src_prev;
    logic [N_SRC-1:0]           src_rise;

    logic [rcf_pkg::FLAG_W-1:0] evt;
    logic [rcf_pkg::FLAG_W-1:0] events;
    logic [rcf_pkg::FLAG_W-1:0] next_events;
    logic [rcf_pkg::FLAG_W-1:0] mask;
    logic [rcf_pkg::FLAG_W-1:0] next_mask;
    logic [rcf_pkg::FLAG_W-1:0] next_flags;
    logic                       next_irq;

    logic                       wr_flags;
    logic                       wr_mask;
    logic                       rd_events;
    logic [rcf_pkg::FLAG_W-1:0] wbyte;
    logic [rcf_pkg::FLAG_W-1:0] rbyte;

    // Address match, used for every register
    function automatic logic rcf_hit(
        input logic [rcf_pkg::ADDR_W-1:0] addr,
        input logic [7:0]                 off
    );
        rcf_hit = (addr == off);
    endfunction : rcf_hit

    // Bus front end
    rcf_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .regif   (regif.bus)
    );

    // Pin is active low; invert ahead of the synchroniser so idle is 0
    assign src_raw[SRC_OVF]  = stack_overflow;
    assign src_raw[SRC_UNF]  = stack_underflow;
    assign src_raw[SRC_WDT]  = watchdog_timeout;
    assign src_raw[SRC_MASTER_CLEAR_PIN] = !master_clear_pin_n;
    assign src_raw[SRC_RI]   = reset_instruction;
    assign src_raw[SRC_BOR]  = brownout;

    // Every source is asynchronous to pclk
    rcf_sync #(
        .WIDTH (N_SRC)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (src_raw),
        .sync_out (src_sync)
    );

    // Rising edge per source: a held level counts once
    assign next_src_prev = src_sync;
    assign src_rise      = src_sync & ~src_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev <= '0;
        end else begin
            src_prev <= next_src_prev;
        end
    end

    // Event vector in register layout; power-on comes only through presetn
    always_comb begin
        evt                        = rcf_pkg::BYTE_ZERO;
        evt[rcf_pkg::BIT_STK_OVF]  = src_rise[SRC_OVF];
        evt[rcf_pkg::BIT_STK_UNF]  = src_rise[SRC_UNF];
        evt[rcf_pkg::BIT_WDT]      = src_rise[SRC_WDT];
        evt[rcf_pkg::BIT_MASTER_CLEAR_PIN]     = src_rise[SRC_MASTER_CLEAR_PIN];
        evt[rcf_pkg::BIT_RST_INSN] = src_rise[SRC_RI];
        evt[rcf_pkg::BIT_BROWNOUT] = src_rise[SRC_BOR];
    end

    // Register decode
    assign wbyte     = regif.wdata[rcf_pkg::FLAG_W-1:0];
    assign wr_flags  = regif.wr_req && rcf_hit(regif.addr, rcf_pkg::OFF_FLAGS);
    assign wr_mask   = regif.wr_req && rcf_hit(regif.addr, rcf_pkg::OFF_MASK);
    assign rd_events = regif.rd_req && rcf_hit(regif.addr, rcf_pkg::OFF_EVENTS);

    // Unmapped offsets answer with pslverr
    assign regif.err = !(rcf_hit(regif.addr, rcf_pkg::OFF_FLAGS)
                      || rcf_hit(regif.addr, rcf_pkg::OFF_EVENTS)
                      || rcf_hit(regif.addr, rcf_pkg::OFF_MASK));

    // Read mux; upper bits of each word read as zero
    always_comb begin
        rbyte = rcf_pkg::BYTE_ZERO;
        if (rcf_hit(regif.addr, rcf_pkg::OFF_FLAGS)) begin
            rbyte = reset_cause_flags & rcf_pkg::FLAGS_WR_MASK;
        end else if (rcf_hit(regif.addr, rcf_pkg::OFF_EVENTS)) begin
            rbyte = events;
        end else if (rcf_hit(regif.addr, rcf_pkg::OFF_MASK)) begin
            rbyte = mask;
        end
        regif.rdata = {rcf_pkg::UPPER_ZERO, rbyte};
    end

    // Cause flags: firmware write first, then hardware events override it,
    // so an event landing in the same cycle as a write is never lost.
    // Each event touches its own bit only.
    always_comb begin
        next_flags = reset_cause_flags;
        if (wr_flags) begin
            next_flags = wbyte & rcf_pkg::FLAGS_WR_MASK;
        end
        if (evt[rcf_pkg::BIT_STK_OVF]) begin
            next_flags[rcf_pkg::BIT_STK_OVF] = 1'b1;
        end
        if (evt[rcf_pkg::BIT_STK_UNF]) begin
            next_flags[rcf_pkg::BIT_STK_UNF] = 1'b1;
        end
        if (evt[rcf_pkg::BIT_WDT]) begin
            next_flags[rcf_pkg::BIT_WDT] = 1'b0;
        end
        if (evt[rcf_pkg::BIT_MASTER_CLEAR_PIN]) begin
            next_flags[rcf_pkg::BIT_MASTER_CLEAR_PIN] = 1'b0;
        end
        if (evt[rcf_pkg::BIT_RST_INSN]) begin
            next_flags[rcf_pkg::BIT_RST_INSN] = 1'b0;
        end
        if (evt[rcf_pkg::BIT_BROWNOUT]) begin
            next_flags[rcf_pkg::BIT_BROWNOUT] = 1'b0;
        end
        next_flags[rcf_pkg::BIT_UNUSED] = 1'b0;
    end

    // Power-on loads idle values: power-on and brown-out bits read 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause_flags <= rcf_pkg::FLAGS_RESET;
        end else begin
            reset_cause_flags <= next_flags;
        end
    end

    // Event status: clear-on-read only of the bits returned, new events win
    always_comb begin
        next_events = events;
        if (rd_events) begin
            next_events = events & ~rbyte;
        end
        next_events = next_events | evt;
        next_mask   = mask;
        if (wr_mask) begin
            next_mask = wbyte & rcf_pkg::FLAGS_WR_MASK;
        end
        // Taken from next values so irq tracks status without extra lag
        next_irq    = |(next_events & next_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= rcf_pkg::EVENTS_RESET;
            mask   <= rcf_pkg::MASK_RESET;
            irq    <= 1'b0;
        end else begin
            events <= next_events;
            mask   <= next_mask;
            irq    <= next_irq;
        end
    end

endmodule : rcf_top

`default_nettype wire

// ---- test/rcf_assertions.sv ----
/*
 * Port checker for the reset cause flag block.
 * Assumes it is bound to rcf_top and sees only that module's ports.
 */
`default_nettype none

module rcf_assertions (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [rcf_pkg::ADDR_W-1:0] paddr,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       stack_overflow,
    input wire logic                       stack_underflow,
    input wire logic                       watchdog_timeout,
    input wire logic                       master_clear_pin_n,
    input wire logic                       reset_instruction,
    input wire logic                       brownout,
    input wire logic [rcf_pkg::FLAG_W-1:0] reset_cause_flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase still waiting; the slave promises exactly one wait state
    sequence waiting_s;
        psel && penable && !pready;
    endsequence
    sequence done_s;
        pready ##1 !pready;
    endsequence

    one_wait_a: assert property (waiting_s |=> done_s) else $error("answer not after one wait");
    err_decode_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("error response wrong for address");
    bit5_zero_a: assert property (reset_cause_flags[5] == 1'b0) else $error("bit 5 not zero");
    ovf_set_a: assert property ($rose(stack_overflow) |-> ##[1:6] reset_cause_flags[7])
        else $error("overflow flag not set");
    unf_set_a: assert property ($rose(stack_underflow) |-> ##[1:6] reset_cause_flags[6])
        else $error("underflow flag not set");
    wdt_clear_a: assert property ($rose(watchdog_timeout) |-> ##[1:6] !reset_cause_flags[4])
        else $error("watchdog flag not cleared");
    pin_clear_a: assert property ($fell(master_clear_pin_n) |-> ##[1:6] !reset_cause_flags[3])
        else $error("pin flag not cleared");
    insn_clear_a: assert property ($rose(reset_instruction) |-> ##[1:6] !reset_cause_flags[2])
        else $error("instruction flag not cleared");
    brown_clear_a: assert property ($rose(brownout) |-> ##[1:6] !reset_cause_flags[0])
        else $error("brown-out bit not cleared");
    // Only a write or a power-on moves the power-on bit
    power_hold_a: assert property ($changed(reset_cause_flags[1]) |-> $past(pready && pwrite))
        else $error("power-on bit moved without a write");
endmodule : rcf_assertions

bind rcf_top rcf_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .stack_overflow(stack_overflow), .stack_underflow(stack_underflow),
    .watchdog_timeout(watchdog_timeout), .master_clear_pin_n(master_clear_pin_n),
    .reset_instruction(reset_instruction), .brownout(brownout),
    .reset_cause_flags(reset_cause_flags));

`default_nettype wire

// ---- test/rcf_top_tb.sv ----
/*
 * Self-checking bench for the reset cause flag block.
 * Assumes rcf_top with the checker bound; events are driven as levels.
 */
`default_nettype none

module rcf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [7:0]  reset_cause_flags;
    logic [5:0]  ev = 6'h00;   // Overflow, underflow, watchdog, pin, instruction, brown-out
    logic [31:0] rd;
    logic        er;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #25 pclk = ~pclk;

    rcf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stack_overflow(ev[5]), .stack_underflow(ev[4]),
        .watchdog_timeout(ev[3]), .master_clear_pin_n(~ev[2]), .reset_instruction(ev[1]),
        .brownout(ev[0]), .reset_cause_flags(reset_cause_flags), .irq(irq));

    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; pready is sampled at the rising edge, where the request still stands
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20) errors++;
        // Answer taken at the completing edge, then the request is released
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_reset_values();
        check("flags port", {24'h0, reset_cause_flags}, 32'h1C);
        apb(1'b0, 8'h00, 32'h0);
        check("flags read", rd, 32'h1C);
        apb(1'b0, 8'h04, 32'h0);
        check("power-on event", rd, 32'h02);
        apb(1'b0, 8'h04, 32'h0);
        check("events cleared", rd, 32'h00);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped read", {rd[30:0], er}, 32'h1);
    endtask : t_reset_values

    // Firmware writes: bit 5 ignored, all others writable, unmapped write ignored
    task automatic t_write_mask();
        apb(1'b1, 8'h00, 32'hFF);
        apb(1'b1, 8'h0C, 32'h00);
        apb(1'b0, 8'h00, 32'h0);
        check("write ff", rd, 32'hDF);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b0, 8'h00, 32'h0);
        check("write 00", rd, 32'h00);
        apb(1'b1, 8'h00, 32'h1F);
        apb(1'b0, 8'h00, 32'h0);
        check("re-arm", rd, 32'h1F);
    endtask : t_write_mask

    // Each event from the armed state touches only its own bit; watchdog alone is unmasked
    task automatic t_events();
        logic [7:0] exp_f [6] = '{8'h9F, 8'h5F, 8'h0F, 8'h17, 8'h1B, 8'h1E};
        apb(1'b1, 8'h08, 32'h10);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'h00, 32'h1F);
            @(posedge pclk);
            ev <= 6'h20 >> i;
            repeat (4) @(posedge pclk);
            ev <= 6'h00;
            repeat (6) @(posedge pclk);
            @(negedge pclk);
            check("event flags", {24'h0, reset_cause_flags}, {24'h0, exp_f[i]});
            check("irq", {31'h0, irq}, {31'h0, i == 2});
            apb(1'b0, 8'h04, 32'h0);
            check("event status", rd, {24'h0, exp_f[i] ^ 8'h1F});
            repeat (2) @(negedge pclk);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
    endtask : t_events

    // Power-on again in mid-run brings the power and brown-out bits back to 0
    task automatic t_second_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(negedge pclk);
        check("flags after reset", {24'h0, reset_cause_flags}, 32'h1C);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        check("power-on event again", rd, 32'h02);
    endtask : t_second_reset

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_write_mask();
        t_events();
        t_second_reset();
        print_verdict();
    end
endmodule : rcf_top_tb

`default_nettype wire
